// ==== shared/rx_ctrl_regs.svh ====
// register offsets, field positions, reset values and timing counts
`ifndef RX_CTRL_REGS_SVH
`define RX_CTRL_REGS_SVH
// ****************************************
// register offsets (byte addresses)
// ****************************************
`define OFS_CTRL 12'h000
`define OFS_CAL 12'h004
`define OFS_AGC 12'h008
`define OFS_PDBW 12'h00C
`define OFS_STAT 12'h010
// ****************************************
// field positions
// ****************************************
`define CAL_START_BIT 9
`define AGC_UP_LSB 5
`define AGC_DOWN_LSB 12
`define AGC_WAIT_LSB 19
`define AGC_SEQ_LSB 23
// ****************************************
// reset values
// ****************************************
`define CTRL_RST 8'h04
`define CAL_DIV_RST 9'h000
`define MAN_LNA_RST 2'h3
`define MAN_FILT_RST 2'h2
`define UP_LEVEL_RST 7'h1E
`define DOWN_LEVEL_RST 7'h46
`define WAIT_CNT_RST 4'hA
`define SEQ_DIV_RST 8'hFA
`define PDBW_RST 10'h009
// ****************************************
// timing
// ****************************************
`define PCLK_MHZ 100
`define CAL_TIME_US 200
`endif

// ==== shared/rx_ctrl_pkg.sv ====
// types shared by the receiver control block
package rx_ctrl_pkg;
   // ****************************************
   // state machines
   // ****************************************
   typedef enum logic {CAL_IDLE, CAL_RUN} cal_state_t;
   typedef enum logic {AGC_MEASURE, AGC_SETTLE} agc_state_t;
   // demodulator select codes
   typedef logic [1:0] demod_code_t;
   localparam demod_code_t DEMOD_LINEAR = 2'h0;
   localparam demod_code_t DEMOD_CORR   = 2'h1;
   localparam demod_code_t DEMOD_ASK    = 2'h2;
endpackage

// ==== shared/rx_ctrl_if.sv ====
// configuration and results between the top and its gain/demod engines
`timescale 1ns/1ps
interface rx_ctrl_if;
   logic       agc_en;
   logic [1:0] man_lna;
   logic [1:0] man_filt;
   logic [6:0] gain_up_level;
   logic [6:0] gain_down_level;
   logic [3:0] settle_wait_count;
   logic [7:0] sequencer_clock_divider;
   logic [6:0] rssi;
   logic [1:0] amp_gain_readback_bits;
   logic [1:0] channel_filter_readback_bits;
   logic [6:0] gain_correction;
   logic [1:0] demod_sel;
   logic [9:0] post_bw;
   logic       i_lim;
   logic       q_lim;
   logic       data_bit;
   modport top (output agc_en, man_lna, man_filt, gain_up_level,
      gain_down_level, settle_wait_count, sequencer_clock_divider, rssi,
      demod_sel, post_bw, i_lim, q_lim,
      input amp_gain_readback_bits, channel_filter_readback_bits,
      gain_correction, data_bit);
   modport agc (input agc_en, man_lna, man_filt, gain_up_level,
      gain_down_level, settle_wait_count, sequencer_clock_divider, rssi,
      output amp_gain_readback_bits, channel_filter_readback_bits,
      gain_correction);
   modport demod (input demod_sel, post_bw, i_lim, q_lim, rssi,
      output data_bit);
endinterface

// ==== logic/agc_loop.sv ====
// gain control loop: threshold stepping, settle wait, manual override
`timescale 1ns/1ps
module agc_loop (
   input wire logic pclk,
   input wire logic presetn,
   rx_ctrl_if.agc   bus
);
   typedef struct packed {
      rx_ctrl_pkg::agc_state_t st;
      logic [2:0]              idx;
      logic [7:0]              pre;
      logic [3:0]              wcnt;
      logic [1:0]              lna;
      logic [1:0]              filt;
      logic [6:0]              corr;
   } agc_state_s_t;
   agc_state_s_t r, n;

   // gain step index to {amp bits, filter bits}; 0 is highest gain
   function automatic logic [3:0] step_bits(input logic [2:0] i);
      case (i)
         3'h0:    step_bits = 4'hE;
         3'h1:    step_bits = 4'hA;
         3'h2:    step_bits = 4'h9;
         3'h3:    step_bits = 4'h8;
         3'h4:    step_bits = 4'h4;
         default: step_bits = 4'h0;
      endcase
   endfunction

   // correction code for a gain pair, 7'h69 for pairs not listed
   function automatic logic [6:0] corr_of(input logic [3:0] b);
      case (b)
         4'hE:    corr_of = 7'h00;
         4'hA:    corr_of = 7'h18;
         4'h9:    corr_of = 7'h2D;
         4'h8:    corr_of = 7'h3F;
         4'h4:    corr_of = 7'h5A;
         default: corr_of = 7'h69;
      endcase
   endfunction

   // next state: step on thresholds, then wait count x divider cycles
   always_comb begin
      n = r;
      case (r.st)
         rx_ctrl_pkg::AGC_MEASURE: begin
            n.pre  = 8'h00;
            n.wcnt = 4'h0;
            if (bus.agc_en && bus.rssi > bus.gain_down_level &&
                r.idx < 3'h5) begin
               n.idx = r.idx + 3'h1;
               n.st  = rx_ctrl_pkg::AGC_SETTLE;
            end else if (bus.agc_en && bus.rssi < bus.gain_up_level &&
                         r.idx != 3'h0) begin
               n.idx = r.idx - 3'h1;
               n.st  = rx_ctrl_pkg::AGC_SETTLE;
            end
         end
         rx_ctrl_pkg::AGC_SETTLE: begin
            // sequencer tick every divider cycles, count ticks
            if (r.pre + 8'h01 >= bus.sequencer_clock_divider) begin
               n.pre  = 8'h00;
               n.wcnt = r.wcnt + 4'h1;
               if (r.wcnt + 4'h1 >= bus.settle_wait_count)
                  n.st = rx_ctrl_pkg::AGC_MEASURE;
            end else begin
               n.pre = r.pre + 8'h01;
            end
         end
         default: n.st = rx_ctrl_pkg::AGC_MEASURE;
      endcase
      // manual gain when the loop is off, else loop's own step
      if (bus.agc_en) begin
         {n.lna, n.filt} = step_bits(n.idx);
      end else begin
         n.lna  = bus.man_lna;
         n.filt = bus.man_filt;
      end
      n.corr = corr_of({n.lna, n.filt});
   end

   // state register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= '{rx_ctrl_pkg::AGC_MEASURE, 3'h0, 8'h00, 4'h0,
                2'h3, 2'h2, 7'h00};
      end else begin
         r <= n;
      end
   end

   assign bus.amp_gain_readback_bits       = r.lna;
   assign bus.channel_filter_readback_bits = r.filt;
   assign bus.gain_correction              = r.corr;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_step_down: assert property (
      r.st == rx_ctrl_pkg::AGC_MEASURE && bus.agc_en && r.idx < 3'h5 &&
      bus.rssi > bus.gain_down_level |=> r.idx == $past(r.idx) + 3'h1)
      else $error("gain not stepped down");
   a_settle_hold: assert property (
      r.st == rx_ctrl_pkg::AGC_SETTLE |=> $stable(r.idx))
      else $error("gain moved while settling");
   a_manual_gain: assert property (
      !bus.agc_en ##1 !bus.agc_en |-> r.lna == $past(bus.man_lna) &&
      r.filt == $past(bus.man_filt))
      else $error("manual gain not applied");
   c_agc_step: cover property (r.st == rx_ctrl_pkg::AGC_SETTLE);
endmodule // agc_loop

// ==== logic/corr_demod.sv ====
// correlator discriminator, post filter and bit slicer
`timescale 1ns/1ps
module corr_demod (
   input wire logic pclk,
   input wire logic presetn,
   rx_ctrl_if.demod bus
);
   typedef struct packed {
      logic               i1;
      logic               q1;
      logic signed [15:0] y1;
      logic signed [15:0] y2;
      logic signed [15:0] avg;
      logic               bit_r;
   } demod_state_t;
   demod_state_t r, n;
   logic signed [15:0] x;
   logic signed [26:0] p1, p2;
   logic signed [2:0]  hi_c, lo_c;

   // two correlators: rotation toward +dev and toward -dev, then filter
   always_comb begin
      n    = r;
      // three bits so the difference of +2 keeps its sign
      hi_c = (r.i1 == bus.q_lim) ? 3'sd1 : -3'sd1;
      lo_c = (r.q1 == bus.i_lim) ? 3'sd1 : -3'sd1;
      if (bus.demod_sel == rx_ctrl_pkg::DEMOD_ASK)
         x = 16'(signed'({1'b0, bus.rssi, 8'h00}));
      else
         x = 16'(signed'({hi_c - lo_c, 13'h0000}));
      n.i1 = bus.i_lim;
      n.q1 = bus.q_lim;
      // second order low pass: two one-pole stages, coefficient bw/1024
      p1   = 27'(x - r.y1) * 27'(signed'({1'b0, bus.post_bw}));
      p2   = 27'(r.y1 - r.y2) * 27'(signed'({1'b0, bus.post_bw}));
      n.y1 = r.y1 + 16'(p1 >>> 10);
      n.y2 = r.y2 + 16'(p2 >>> 10);
      n.avg = r.avg + 16'((r.y2 - r.avg) >>> 8);
      // correlator slices at zero, the others at the running average
      if (bus.demod_sel == rx_ctrl_pkg::DEMOD_CORR)
         n.bit_r = r.y2 > 16'sh0000;
      else
         n.bit_r = r.y2 > r.avg;
   end

   // state register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   assign bus.data_bit = r.bit_r;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_fixed_zero: assert property (
      bus.demod_sel == rx_ctrl_pkg::DEMOD_CORR && r.y2 < 16'sh0000
      |=> !r.bit_r)
      else $error("slicer not at zero");
   c_corr_one: cover property (
      bus.demod_sel == rx_ctrl_pkg::DEMOD_CORR && r.bit_r);
endmodule // corr_demod

// ==== logic/rx_ctrl.sv ====
// receiver control top: apb registers, calibration, offset clock divider
`timescale 1ns/1ps
`include "rx_ctrl_regs.svh"
module rx_ctrl #(
   parameter int unsigned CAL_CYCLES = `CAL_TIME_US * `PCLK_MHZ
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [6:0]  rssi_adc,
   input  wire logic        i_lim_pin,
   input  wire logic        q_lim_pin,
   input  wire logic [5:0]  cal_trim_in,
   output logic      [1:0]  if_filter_bw,
   output logic      [8:0]  if_cal_divider,
   output logic             cal_busy,
   output logic      [5:0]  cal_trim,
   output logic             front_amp_operating_select,
   output logic             mixer_linearity,
   output logic      [1:0]  lna_gain,
   output logic      [1:0]  filter_gain,
   output logic             baseband_offset_clock,
   output logic             rx_data
);
   // ****************************************
   // state
   // ****************************************
   typedef struct packed {
      logic                    rdy;
      logic                    err;
      logic [31:0]             rdata;
      logic [7:0]              ctrl;
      logic [8:0]              cal_div;
      logic [9:0]              pdbw;
      logic                    agc_en;
      logic [1:0]              man_lna;
      logic [1:0]              man_filt;
      logic [6:0]              up_lvl;
      logic [6:0]              down_lvl;
      logic [3:0]              wait_cnt;
      logic [7:0]              seq_div;
      rx_ctrl_pkg::cal_state_t cal_st;
      logic [14:0]             cal_cnt;
      logic [5:0]              trim;
      logic [3:0]              os_cnt;
      logic                    os_pulse;
      logic [6:0]              rssi_s1;
      logic [6:0]              rssi_s2;
      logic [5:0]              trim_s1;
      logic [5:0]              trim_s2;
      logic [1:0]              iq_s1;
      logic [1:0]              iq_s2;
      logic                    rx_bit;
      logic [1:0]              lna;
      logic [1:0]              filt;
   } top_state_t;
   top_state_t r, n;

   localparam logic [14:0] CAL_LAST = 15'(CAL_CYCLES - 1);

   rx_ctrl_if ifc ();

   logic       acc_first;
   logic       wr_take;
   logic [2:0] sel_idx;
   logic [3:0] os_div;

   // register index from address; 3'h7 marks an unmapped address
   function automatic logic [2:0] reg_index(input logic [11:0] a);
      case (a)
         `OFS_CTRL: reg_index = 3'h0;
         `OFS_CAL:  reg_index = 3'h1;
         `OFS_AGC:  reg_index = 3'h2;
         `OFS_PDBW: reg_index = 3'h3;
         `OFS_STAT: reg_index = 3'h4;
         default:   reg_index = 3'h7;
      endcase
   endfunction

   // offset clock ratio: 00 by 4, 01 by 8, 10 and 11 by 16
   function automatic logic [3:0] os_ratio_last(input logic [1:0] s);
      case (s)
         2'h0:    os_ratio_last = 4'h3;
         2'h1:    os_ratio_last = 4'h7;
         default: os_ratio_last = 4'hF;
      endcase
   endfunction

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      n = r;
      // pin inputs through two flops before any use
      n.rssi_s1 = rssi_adc;
      n.rssi_s2 = r.rssi_s1;
      n.trim_s1 = cal_trim_in;
      n.trim_s2 = r.trim_s1;
      n.iq_s1   = {i_lim_pin, q_lim_pin};
      n.iq_s2   = r.iq_s1;
      // apb: one wait state, data and error ready with pready
      acc_first = psel && penable && !r.rdy;
      wr_take   = psel && penable && r.rdy && pwrite;
      sel_idx   = reg_index(paddr);
      n.rdy     = acc_first;
      n.err     = acc_first && (sel_idx == 3'h7);
      n.rdata   = 32'h0000_0000;
      if (acc_first && !pwrite) begin
         case (sel_idx)
            3'h0: n.rdata = {24'h00_0000, r.ctrl};
            3'h1: n.rdata = {15'h0000, r.trim, r.cal_st ==
                             rx_ctrl_pkg::CAL_RUN, 1'b0, r.cal_div};
            3'h2: n.rdata = {1'b0, r.seq_div, r.wait_cnt, r.down_lvl,
                             r.up_lvl, r.man_filt, r.man_lna, r.agc_en};
            3'h3: n.rdata = {22'h00_0000, r.pdbw};
            // strength readback with gain bits and correction
            3'h4: n.rdata = {12'h000, r.cal_st == rx_ctrl_pkg::CAL_RUN,
                             r.rx_bit, ifc.gain_correction, r.filt,
                             r.lna, r.rssi_s2};
            default: n.rdata = 32'h0000_0000;
         endcase
      end
      // register writes take effect on the edge with pready high
      if (wr_take) begin
         case (sel_idx)
            3'h0: n.ctrl = pwdata[7:0];
            3'h1: n.cal_div = pwdata[8:0];
            3'h2: begin
               n.agc_en   = pwdata[0];
               n.man_lna  = pwdata[2:1];
               n.man_filt = pwdata[4:3];
               n.up_lvl   = pwdata[`AGC_UP_LSB +: 7];
               n.down_lvl = pwdata[`AGC_DOWN_LSB +: 7];
               n.wait_cnt = pwdata[`AGC_WAIT_LSB +: 4];
               n.seq_div  = pwdata[`AGC_SEQ_LSB +: 8];
            end
            3'h3: n.pdbw = pwdata[9:0];
            default: n.ctrl = r.ctrl;
         endcase
      end
      // calibration timer: busy for the whole interval, then latch trim
      case (r.cal_st)
         rx_ctrl_pkg::CAL_IDLE: begin
            if (wr_take && sel_idx == 3'h1 && pwdata[`CAL_START_BIT]) begin
               n.cal_st  = rx_ctrl_pkg::CAL_RUN;
               n.cal_cnt = CAL_LAST;
            end
         end
         rx_ctrl_pkg::CAL_RUN: begin
            if (r.cal_cnt == 15'h0000) begin
               n.cal_st = rx_ctrl_pkg::CAL_IDLE;
               n.trim   = r.trim_s2;
            end else begin
               n.cal_cnt = r.cal_cnt - 15'h0001;
            end
         end
         default: n.cal_st = rx_ctrl_pkg::CAL_IDLE;
      endcase
      // offset correction clock as a one-cycle enable
      os_div = os_ratio_last(r.ctrl[5:4]);
      if (r.os_cnt >= os_div) begin
         n.os_cnt   = 4'h0;
         n.os_pulse = 1'b1;
      end else begin
         n.os_cnt   = r.os_cnt + 4'h1;
         n.os_pulse = 1'b0;
      end
      // gain and data outputs re-registered for flop-driven pins
      n.lna    = ifc.amp_gain_readback_bits;
      n.filt   = ifc.channel_filter_readback_bits;
      n.rx_bit = ifc.data_bit;
   end

   // ****************************************
   // state register
   // ****************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r          <= '0;
         r.ctrl     <= `CTRL_RST;
         r.cal_div  <= `CAL_DIV_RST;
         r.pdbw     <= `PDBW_RST;
         r.agc_en   <= 1'b1;
         r.man_lna  <= `MAN_LNA_RST;
         r.man_filt <= `MAN_FILT_RST;
         r.up_lvl   <= `UP_LEVEL_RST;
         r.down_lvl <= `DOWN_LEVEL_RST;
         r.wait_cnt <= `WAIT_CNT_RST;
         r.seq_div  <= `SEQ_DIV_RST;
         r.cal_st   <= rx_ctrl_pkg::CAL_IDLE;
         r.lna      <= `MAN_LNA_RST;
         r.filt     <= `MAN_FILT_RST;
      end else begin
         r <= n;
      end
   end

   // ****************************************
   // engines
   // ****************************************
   // configuration to the gain loop and the demodulator
   assign ifc.agc_en                  = r.agc_en;
   assign ifc.man_lna                 = r.man_lna;
   assign ifc.man_filt                = r.man_filt;
   assign ifc.gain_up_level           = r.up_lvl;
   assign ifc.gain_down_level         = r.down_lvl;
   assign ifc.settle_wait_count       = r.wait_cnt;
   assign ifc.sequencer_clock_divider = r.seq_div;
   assign ifc.rssi                    = r.rssi_s2;
   assign ifc.demod_sel               = r.ctrl[3:2];
   assign ifc.post_bw                 = r.pdbw;
   assign ifc.i_lim                   = r.iq_s2[1];
   assign ifc.q_lim                   = r.iq_s2[0];

   agc_loop u_agc (
      .pclk    (pclk),
      .presetn (presetn),
      .bus     (ifc.agc)
   );

   corr_demod u_demod (
      .pclk    (pclk),
      .presetn (presetn),
      .bus     (ifc.demod)
   );

   // ****************************************
   // outputs
   // ****************************************
   assign prdata                     = r.rdata;
   assign pready                     = r.rdy;
   assign pslverr                    = r.err;
   assign if_filter_bw               = r.ctrl[1:0];
   assign front_amp_operating_select = r.ctrl[6];
   assign mixer_linearity            = r.ctrl[7];
   assign if_cal_divider             = r.cal_div;
   assign cal_busy                   = r.cal_st == rx_ctrl_pkg::CAL_RUN;
   assign cal_trim                   = r.trim;
   assign lna_gain                   = r.lna;
   assign filter_gain                = r.filt;
   assign baseband_offset_clock      = r.os_pulse;
   assign rx_data                    = r.rx_bit;

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // cycles spent busy, for the interval length check
   logic [15:0] busy_len;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) busy_len <= 16'h0000;
      else if (cal_busy) busy_len <= busy_len + 16'h0001;
      else busy_len <= 16'h0000;
   end

   a_cal_length: assert property (
      $fell(cal_busy) |-> $past(busy_len) == 16'(CAL_CYCLES - 1))
      else $error("calibration interval wrong");
   a_cal_trim: assert property (
      $fell(cal_busy) |-> cal_trim == $past(r.trim_s2))
      else $error("trim not latched at end");
   a_apb_wait: assert property (
      psel && penable && !pready |=> pready ##1 !pready)
      else $error("apb answer not one wait state");
   a_unmapped: assert property (
      pready |-> pslverr == (reg_index(paddr) == 3'h7))
      else $error("bad error answer");
   a_os_period: assert property (
      baseband_offset_clock && r.ctrl[5:4] == 2'h0 ##1
      $stable(r.ctrl[5:4]) [*3] |=> baseband_offset_clock)
      else $error("offset clock ratio wrong");
   a_agc_off: assert property (
      pready && pwrite && paddr == `OFS_AGC && !pwdata[0] |=> !r.agc_en)
      else $error("gain loop not disabled");
   c_cal_done: cover property ($fell(cal_busy));
   c_write: cover property (pready && pwrite && !pslverr);
   c_read_stat: cover property (pready && !pwrite && paddr == `OFS_STAT);
endmodule // rx_ctrl

// ==== bench/front_end_model.sv ====
// analog front end model: strength code, limiter pair and filter trim
`timescale 1ns/1ps
module front_end_model #(
   parameter logic [5:0] TRIM = 6'h2D  // arbitrary trim value
) (
   input  wire logic       pclk,
   input  wire logic [6:0] level,
   input  wire logic       rev,
   output logic      [6:0] rssi_adc,
   output logic            i_lim_pin,
   output logic            q_lim_pin,
   output logic      [5:0] cal_trim_in
);
   logic [1:0] ph = 2'h0;
   // limiters rotate in quadrature, one phase step per clock
   always_ff @(posedge pclk) begin
      ph <= ph + 2'h1;
   end
   assign i_lim_pin   = ph[1];
   // exact deviation tone, no frequency error
   assign q_lim_pin   = ph[1] ^ ph[0] ^ rev;
   assign rssi_adc    = level;
   assign cal_trim_in = TRIM;
endmodule  // front_end_model

// ==== bench/rx_ctrl_bench.sv ====
// self-checking bench for the receiver control block
`timescale 1ns/1ps
module rx_ctrl_bench;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic        busy, fa, ml, boc, rxd, il, ql, se, rev;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [1:0]  bw, lg, fg;
   logic [8:0]  cdv;
   logic [5:0]  trim, tin;
   logic [6:0]  lvl, rssi;
   int          err_count, num_checks, n;
   rx_ctrl #(.CAL_CYCLES(50)) rx_ctrl_inst (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .rssi_adc(rssi), .i_lim_pin(il), .q_lim_pin(ql), .cal_trim_in(tin),
      .if_filter_bw(bw), .if_cal_divider(cdv), .cal_busy(busy),
      .cal_trim(trim), .front_amp_operating_select(fa),
      .mixer_linearity(ml), .lna_gain(lg), .filter_gain(fg),
      .baseband_offset_clock(boc), .rx_data(rxd));
   front_end_model front_end_model_inst (.pclk(pclk), .level(lvl), .rev(rev),
      .rssi_adc(rssi), .i_lim_pin(il), .q_lim_pin(ql), .cal_trim_in(tin));
   // ****************************************
   // tasks
   // ****************************************
   task automatic chk(input string nm, input logic [31:0] e, g);
      num_checks++;
      if (g !== e) begin
         err_count++;
         $display("Error %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic wrap_up;
      if (err_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // one apb transfer, held until pready is seen at a rising edge
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      @(posedge pclk);
      while (pready !== 1'b1 && k < 20) begin
         @(posedge pclk);
         k++;
      end
      if (pready !== 1'b1) chk("pready", 1, 0);
      // answer taken at the edge where pready is sampled high
      rd = prdata;
      se = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // count offset clock pulses over a fixed span
   task automatic cnt(input int cy);
      n = 0;
      repeat (cy) begin
         @(negedge pclk);
         if (boc === 1'b1) n++;
      end
   endtask
   // ****************************************
   // clock, reset, watchdog and tests
   // ****************************************
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   initial begin
      repeat (40000) @(posedge pclk);
      err_count++;
      wrap_up;
   end
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      rev = 1'b0;
      lvl = 7'h32;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      apb(0, 12'h000, 0); chk("ctrl", 32'h0000_0004, rd);
      chk("ctrl_err", 0, 32'(se));
      chk("rst_gain", 32'h0000_000E, 32'({lg, fg}));
      apb(0, 12'h008, 0); chk("agc", 32'h7D54_63D7, rd);
      apb(0, 12'h00C, 0); chk("pdbw", 32'h0000_0009, rd);
      apb(0, 12'h020, 0); chk("unmapped", 0, rd);
      chk("slverr", 1, 32'(se));
      for (int c = 0; c < 3; c++) begin
         apb(1, 12'h000, 32'h0000_00C7 | (c << 4));
         cnt(64); chk("offset", 64 >> (c + 2), n);
      end
      chk("mode", 32'h0000_000F, 32'({fa, ml, bw}));
      // correlator: tone below, then above the centre
      chk("corr_lo", 0, 32'(rxd));
      rev <= 1'b1;
      repeat (2000) @(posedge pclk);
      chk("corr_hi", 1, 32'(rxd));
      // one calibration after the clock has settled, bus left idle
      apb(1, 12'h004, 32'h0000_0355);
      @(negedge pclk);
      n = 0;
      while (busy === 1'b1 && n < 200) begin
         @(negedge pclk);
         n++;
      end
      chk("busy", 50, n);
      chk("trim", 32'(tin), 32'(trim));
      chk("div", 32'h0000_0155, 32'(cdv));
      // amplitude demodulation, default loop settings: 2500 cycle settle
      apb(1, 12'h000, 32'h0000_00EB);
      apb(1, 12'h008, 32'h7D54_63D7);
      lvl <= 7'h64;
      repeat (300) @(posedge pclk);
      chk("ask_rise", 1, 32'(rxd));
      chk("step1", 32'h0000_000A, 32'({lg, fg}));
      repeat (2190) @(posedge pclk);
      chk("settle", 32'h0000_000A, 32'({lg, fg}));
      repeat (30) @(posedge pclk);
      chk("step2", 32'h0000_0009, 32'({lg, fg}));
      repeat (10580) @(posedge pclk);
      apb(0, 12'h010, 0);
      chk("down", 32'h0003_4864, 32'(rd[17:0]));
      chk("gain", 0, 32'({lg, fg}));
      lvl <= 7'h0A;
      repeat (300) @(posedge pclk);
      chk("ask_fall", 0, 32'(rxd));
      repeat (12800) @(posedge pclk);
      apb(0, 12'h010, 0);
      chk("up", 32'h0000_058A, 32'(rd[17:0]));
      apb(1, 12'h008, 32'h7D54_63C2);
      apb(0, 12'h010, 0);
      chk("man", 32'h0002_D08A, 32'(rd[17:0]));
      chk("mgain", 32'h0000_0004, 32'({lg, fg}));
      wrap_up;
   end
endmodule  // rx_ctrl_bench
